// *** test/rslp_seq_model.sv ***
/*
  Behavioural model of the external sequencer that drives the control pins.
  Assumes the bench calls its tasks; it keeps mirror copies of both pointers.
*/
module rslp_seq_model
  import rslp_pkg::*;
(
  input  wire logic         clk,        // System clock
  output logic [LINE_W-1:0] line_addr,  // Start line bus
  output rslp_ctrl_t        ctrl        // Control pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [LINE_W-1:0] start_m;
  logic [LINE_W-1:0] mir_rd;
  logic [LINE_W-1:0] mir_rs;
  initial begin
    line_addr = LINE_RST;
    ctrl      = '0;
    start_m   = LINE_RST;
    mir_rd    = LINE_RST;
    mir_rs    = LINE_RST;
  end
  function automatic logic [LINE_W-1:0] step_of(input logic [LINE_W-1:0] v);
    step_of = (v == LINE_MAX) ? v : v + LINE_STEP;
  endfunction : step_of
  task automatic set(input int b, input logic v);
    @(posedge clk);
    #1;
    ctrl[b] = v;
  endtask : set
  // Every level is held seven cycles, well above the pin minimum
  task automatic pulse(input int b);
    set(b, 1'b1);
    repeat (6) @(posedge clk);
    set(b, 1'b0);
    repeat (6) @(posedge clk);
  endtask : pulse
  task automatic load_start(input logic [LINE_W-1:0] v);
    @(posedge clk);
    #1;
    line_addr = v;
    repeat (3) @(posedge clk);
    pulse(10);
    start_m   = v;
    line_addr = ~v; // Bus driven to the inverse of the loaded value: old value not kept
  endtask : load_start
  task automatic preset_read();
    pulse(9);
    mir_rd = start_m;
  endtask : preset_read
  task automatic preset_reset();
    pulse(8);
    mir_rs = start_m;
  endtask : preset_reset
  task automatic clk_read();
    pulse(7);
    mir_rd = step_of(mir_rd);
  endtask : clk_read
  task automatic clk_reset();
    pulse(6);
    mir_rs = step_of(mir_rs);
  endtask : clk_reset
  task automatic advance(input logic [LINE_W-1:0] roi_end);
    if (mir_rd == roi_end) preset_read();
    else clk_read();
  endtask : advance
  // Step the read pointer without its clock: load the next line, then preset
  task automatic reload_step_read();
    load_start(step_of(mir_rd));
    preset_read();
  endtask : reload_step_read
  task automatic line_cycle();
    set(5, SIDE_READ);
    pulse(2);
    pulse(1);
    set(5, SIDE_RESET);
    pulse(4);
    set(5, SIDE_READ);
  endtask : line_cycle
endmodule : rslp_seq_model

// *** test/test_rslp_line_ctrl.sv ***
/*
  Self-checking bench for the line-pointer control block.
  Assumes the sequencer model drives the control and line-address pins and holds the expected pointers.
*/
module test_rslp_line_ctrl
  import rslp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk;
  logic              reset_n;
  logic [LINE_W-1:0] line_addr;
  rslp_ctrl_t        ctrl;
  logic [LINE_W-1:0] rd_ptr;
  logic [LINE_W-1:0] rs_ptr;
  logic              rd_sat;
  logic              rs_sat;
  rslp_row_t         row_drive;
  rslp_op_t          row_op;
  logic              offset_cal;
  int                errors;
  int                compares;
  rslp_seq_model u_rslp_seq_model (.clk(clk), .line_addr(line_addr), .ctrl(ctrl));
  rslp_line_ctrl u_rslp_line_ctrl (.clk(clk), .reset_n(reset_n), .line_addr(line_addr), .ctrl(ctrl),
    .read_line_pointer(rd_ptr), .reset_line_pointer(rs_ptr), .read_pointer_saturated_flag(rd_sat),
    .pointer_saturated_flag_alt(rs_sat), .row_drive(row_drive), .row_op(row_op), .offset_cal(offset_cal));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  task automatic check_val(input string name, input logic [LINE_W-1:0] exp, input logic [LINE_W-1:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val
  task automatic check_ptrs();
    check_val("read_line_pointer", u_rslp_seq_model.mir_rd, rd_ptr);
    check_val("reset_line_pointer", u_rslp_seq_model.mir_rs, rs_ptr);
  endtask : check_ptrs
  task automatic wait6();
    repeat (6) @(posedge clk);
    #1;
  endtask : wait6
  task automatic end_test(input string name);
    $display("Test %s done, errors %0d", name, errors);
  endtask : end_test
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial begin
    errors   = 0;
    compares = 0;
    reset_n  = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    wait6();
    check_ptrs();
    check_val("flags", 10'h000, {8'h00, rd_sat, rs_sat});
    end_test("reset");
    u_rslp_seq_model.load_start(10'h005);
    u_rslp_seq_model.preset_read();
    check_ptrs();
    u_rslp_seq_model.clk_read();
    u_rslp_seq_model.clk_read();
    check_ptrs();
    end_test("load_preset_step");
    u_rslp_seq_model.load_start(10'h3FE);
    u_rslp_seq_model.preset_reset();
    u_rslp_seq_model.clk_reset();
    check_val("reset_line_pointer", 10'h3FF, rs_ptr);
    check_val("flags", 10'h001, {8'h00, rd_sat, rs_sat});
    u_rslp_seq_model.clk_reset();
    check_val("reset_line_pointer", 10'h3FF, rs_ptr);
    u_rslp_seq_model.load_start(10'h003);
    u_rslp_seq_model.preset_reset();
    check_ptrs();
    check_val("flags", 10'h000, {8'h00, rd_sat, rs_sat});
    end_test("saturation");
    u_rslp_seq_model.set(5, SIDE_READ);
    u_rslp_seq_model.set(3, 1'b1);
    wait6();
    check_val("row", 10'h007, row_drive.row);
    check_val("sel", 10'h001, {9'h000, row_drive.sel});
    u_rslp_seq_model.set(5, SIDE_RESET);
    u_rslp_seq_model.set(3, 1'b0);
    u_rslp_seq_model.set(4, 1'b1);
    wait6();
    check_val("row", 10'h003, row_drive.row);
    check_val("reset_op", {8'h00, RSLP_OP_RESET_ROW}, {8'h00, row_op});
    u_rslp_seq_model.set(4, 1'b0);
    u_rslp_seq_model.set(5, SIDE_READ);
    u_rslp_seq_model.set(2, 1'b1);
    wait6();
    check_val("shs", 10'h001, {9'h000, row_drive.shs});
    check_val("sample_s_op", {8'h00, RSLP_OP_SAMPLE_S}, {8'h00, row_op});
    u_rslp_seq_model.set(2, 1'b0);
    for (int i = 0; i < 12 && row_drive.pd_reset !== 1'b1; i++) @(posedge clk) #1;
    check_val("pd_reset", 10'h001, {9'h000, row_drive.pd_reset});
    check_val("pd_row", 10'h007, row_drive.row);
    u_rslp_seq_model.set(1, 1'b1);
    wait6();
    check_val("shr", 10'h001, {9'h000, row_drive.shr});
    check_val("sample_r_op", {8'h00, RSLP_OP_SAMPLE_R}, {8'h00, row_op});
    u_rslp_seq_model.set(1, 1'b0);
    wait6();
    check_val("shr", 10'h000, {9'h000, row_drive.shr});
    end_test("row_ops");
    u_rslp_seq_model.load_start(10'h005);
    u_rslp_seq_model.line_cycle();
    u_rslp_seq_model.advance(10'h008);
    u_rslp_seq_model.advance(10'h008);
    check_val("read_line_pointer", 10'h005, rd_ptr);
    check_ptrs();
    u_rslp_seq_model.reload_step_read();
    check_val("read_line_pointer", 10'h006, rd_ptr);
    check_ptrs();
    end_test("roi_wrap");
    u_rslp_seq_model.set(0, 1'b1);
    wait6();
    check_val("offset_cal", 10'h001, {9'h000, offset_cal});
    u_rslp_seq_model.set(0, 1'b0);
    wait6();
    check_val("offset_cal", 10'h000, {9'h000, offset_cal});
    end_test("calibration");
    print_verdict();
  end
endmodule : test_rslp_line_ctrl

// *** verilog/rslp_line_ctrl.sv ***
/*
  Line-pointer and row-operation control of a rolling-shutter sensor without an
  on-chip sequencer. Holds line-start register, read and reset pointers, flags,
  side selection and calibration request.
  Assumes all control pins come from an external sequencer, asynchronous to clk.
*/
module rslp_line_ctrl
  import rslp_pkg::*;
(
  input  wire logic              clk,                      // 125 MHz clock
  input  wire logic              reset_n,                  // Async reset, active low
  input  wire logic [LINE_W-1:0] line_addr,                // Start line bus pins
  input  wire rslp_ctrl_t        ctrl,                     // Control pins
  output logic [LINE_W-1:0]      read_line_pointer,        // Read pointer content
  output logic [LINE_W-1:0]      reset_line_pointer,       // Reset pointer content
  output logic                   read_pointer_saturated_flag, // Read pointer saturated
  output logic                   pointer_saturated_flag_alt,  // Reset pointer saturated
  output rslp_row_t              row_drive,                // Row address and switches
  output rslp_op_t               row_op,                   // Current row operation
  output logic                   offset_cal                // Amplifier offset to reference
);
  logic [1:0]        rst_sync_r;
  logic              rst_n;
  rslp_ctrl_t        ctrl_m_r;
  rslp_ctrl_t        ctrl_s_r;
  rslp_ctrl_t        ctrl_d_r;
  logic [LINE_W-1:0] addr_m_r;
  logic [LINE_W-1:0] addr_s_r;
  logic [LINE_W-1:0] start_r;
  logic [LINE_W-1:0] start_nxt;
  logic              load_edge;
  logic              rd_preset_edge;
  logic              rs_preset_edge;
  logic              rd_step_edge;
  logic              rs_step_edge;
  logic              sample_s_fall;
  logic              pd_auto_r;
  logic [LINE_W-1:0] row_sel;
  rslp_row_t         row_nxt;
  rslp_row_t         row_r;
  rslp_op_t          op_nxt;
  rslp_op_t          op_r;
  logic              cal_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rst_sync_r <= SYNC_RST;
    else          rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Two-flop synchronisers for pins, plus a delay stage for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_m_r <= '0;
      ctrl_s_r <= '0;
      ctrl_d_r <= '0;
      addr_m_r <= LINE_RST;
      addr_s_r <= LINE_RST;
    end else begin
      ctrl_m_r <= ctrl;
      ctrl_s_r <= ctrl_m_r;
      ctrl_d_r <= ctrl_s_r;
      addr_m_r <= line_addr;
      addr_s_r <= addr_m_r;
    end
  end

  assign load_edge      = ctrl_s_r.load & ~ctrl_d_r.load;
  assign rd_preset_edge = ctrl_s_r.read_preset & ~ctrl_d_r.read_preset;
  assign rs_preset_edge = ctrl_s_r.reset_preset & ~ctrl_d_r.reset_preset;
  assign rd_step_edge   = ctrl_s_r.read_clk & ~ctrl_d_r.read_clk;
  assign rs_step_edge   = ctrl_s_r.reset_clk & ~ctrl_d_r.reset_clk;
  assign sample_s_fall  = ~ctrl_s_r.sample_s & ctrl_d_r.sample_s;

  // Line-start register keeps its value for reuse
  assign start_nxt = load_edge ? addr_s_r : start_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) start_r <= LINE_RST;
    else        start_r <= start_nxt;
  end

  rslp_pointer u_read_ptr (
    .clk        (clk),
    .rst_n      (rst_n),
    .step       (rd_step_edge),
    .preset     (rd_preset_edge),
    .start_line (start_r),
    .line       (read_line_pointer),
    .saturated  (read_pointer_saturated_flag)
  );

  rslp_pointer u_reset_ptr (
    .clk        (clk),
    .rst_n      (rst_n),
    .step       (rs_step_edge),
    .preset     (rs_preset_edge),
    .start_line (start_r),
    .line       (reset_line_pointer),
    .saturated  (pointer_saturated_flag_alt)
  );

  // Photodiode reset pulse right after the signal sample ends, read side only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pd_auto_r <= 1'b0;
    else        pd_auto_r <= sample_s_fall & (ctrl_s_r.side_sel == SIDE_READ);
  end

  assign row_sel = (ctrl_s_r.side_sel == SIDE_RESET) ? reset_line_pointer : read_line_pointer;

  always_comb begin
    row_nxt          = '0;
    row_nxt.row      = row_sel;
    row_nxt.pd_reset = ctrl_s_r.row_reset | pd_auto_r;
    row_nxt.sel      = ctrl_s_r.row_select;
    row_nxt.shs      = ctrl_s_r.sample_s;
    row_nxt.shr      = ctrl_s_r.sample_r;
  end

  assign op_nxt = row_nxt.pd_reset ? RSLP_OP_RESET_ROW :
                  row_nxt.shs      ? RSLP_OP_SAMPLE_S  :
                  row_nxt.shr      ? RSLP_OP_SAMPLE_R  : RSLP_OP_NONE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      row_r <= '0;
      op_r  <= RSLP_OP_NONE;
      cal_r <= 1'b0;
    end else begin
      row_r <= row_nxt;
      op_r  <= op_nxt;
      cal_r <= ctrl_s_r.cal;
    end
  end

  assign row_drive  = row_r;
  assign row_op     = op_r;
  assign offset_cal = cal_r;

  property p_side_read;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_s_r.side_sel == SIDE_READ) |=> (row_r.row == $past(read_line_pointer));
  endproperty
  a_side_read: assert property (p_side_read) else $error("row not from read pointer");

  property p_side_reset;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_s_r.side_sel == SIDE_RESET) |=> (row_r.row == $past(reset_line_pointer));
  endproperty
  a_side_reset: assert property (p_side_reset) else $error("row not from reset pointer");

  sequence s_sample_end;
    sample_s_fall && (ctrl_s_r.side_sel == SIDE_READ);
  endsequence
  property p_auto_reset;
    @(posedge clk) disable iff (!rst_n)
      s_sample_end |-> ##2 row_r.pd_reset;
  endproperty
  a_auto_reset: assert property (p_auto_reset) else $error("no photodiode reset after sample");

  property p_load;
    @(posedge clk) disable iff (!rst_n)
      load_edge |=> (start_r == $past(addr_s_r));
  endproperty
  a_load: assert property (p_load) else $error("start line not loaded");

  property p_flag;
    @(posedge clk) disable iff (!rst_n)
      read_pointer_saturated_flag == (read_line_pointer == LINE_MAX);
  endproperty
  a_flag: assert property (p_flag) else $error("saturation flag wrong");

  property p_cal;
    @(posedge clk) disable iff (!rst_n)
      ctrl_s_r.cal |=> offset_cal;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration not applied");

  // A step on one pointer leaves the other pointer where it was
  property p_own_step_read;
    @(posedge clk) disable iff (!rst_n)
      rd_step_edge && !rs_step_edge && !rs_preset_edge |=> $stable(reset_line_pointer);
  endproperty
  a_own_step_read: assert property (p_own_step_read) else $error("read step moved reset pointer");

  property p_own_step_reset;
    @(posedge clk) disable iff (!rst_n)
      rs_step_edge && !rd_step_edge && !rd_preset_edge |=> $stable(read_line_pointer);
  endproperty
  a_own_step_reset: assert property (p_own_step_reset) else $error("reset step moved read pointer");

  // Last step below maximum must raise the flag on the next cycle
  property p_sat_rise;
    @(posedge clk) disable iff (!rst_n)
      rs_step_edge && !rs_preset_edge && (reset_line_pointer == LINE_MAX - LINE_STEP)
      |=> pointer_saturated_flag_alt;
  endproperty
  a_sat_rise: assert property (p_sat_rise) else $error("reset pointer flag did not rise");

  property p_op_reset;
    @(posedge clk) disable iff (!rst_n)
      row_nxt.pd_reset |=> (row_op == RSLP_OP_RESET_ROW);
  endproperty
  a_op_reset: assert property (p_op_reset) else $error("reset operation not reported");

  property p_sample_s;
    @(posedge clk) disable iff (!rst_n)
      ctrl_s_r.sample_s |=> row_drive.shs;
  endproperty
  a_sample_s: assert property (p_sample_s) else $error("signal sample switch not driven");

  property p_sample_r;
    @(posedge clk) disable iff (!rst_n)
      ctrl_s_r.sample_r |=> row_drive.shr;
  endproperty
  a_sample_r: assert property (p_sample_r) else $error("reset sample switch not driven");
endmodule : rslp_line_ctrl

// *** verilog/rslp_pkg.sv ***
/*
  Package for the rolling-shutter line-pointer control block: widths, reset values,
  row-operation encodings and carrier structs.
  Assumes a single clock domain; control pins are synchronised in the top module.
*/
package rslp_pkg;
  localparam int          LINE_W       = 10;
  localparam logic [9:0]  LINE_MAX     = 10'h3FF;
  localparam logic [9:0]  LINE_RST     = 10'h000;
  localparam logic [9:0]  LINE_STEP    = 10'h001;
  localparam logic        SIDE_READ    = 1'b0;
  localparam logic        SIDE_RESET   = 1'b1;
  localparam logic [1:0]  SYNC_RST     = 2'h0;

  typedef enum logic [1:0] {
    RSLP_OP_NONE,
    RSLP_OP_RESET_ROW,
    RSLP_OP_SAMPLE_S,
    RSLP_OP_SAMPLE_R
  } rslp_op_t;

  // Control pin group, one bit per strobe or clock
  typedef struct packed {
    logic              load;
    logic              read_preset;
    logic              reset_preset;
    logic              read_clk;
    logic              reset_clk;
    logic              side_sel;
    logic              row_reset;
    logic              row_select;
    logic              sample_s;
    logic              sample_r;
    logic              cal;
  } rslp_ctrl_t;

  // Row drive towards the pixel array
  typedef struct packed {
    logic [LINE_W-1:0] row;
    logic              pd_reset;
    logic              sel;
    logic              shs;
    logic              shr;
  } rslp_row_t;

  function automatic logic [LINE_W-1:0] rslp_sat_inc(input logic [LINE_W-1:0] v);
    rslp_sat_inc = (v == LINE_MAX) ? v : v + LINE_STEP;
  endfunction : rslp_sat_inc
endpackage : rslp_pkg

// *** verilog/rslp_pointer.sv ***
/*
  One saturating line-pointer register with its own step clock and preset.
  Assumes step and preset arrive as synchronised single-cycle edge pulses.
*/
module rslp_pointer
  import rslp_pkg::*;
(
  input  wire logic              clk,          // System clock
  input  wire logic              rst_n,        // Synchronised reset
  input  wire logic              step,         // Advance pulse
  input  wire logic              preset,       // Copy start value pulse
  input  wire logic [LINE_W-1:0] start_line,   // Line-start register value
  output logic      [LINE_W-1:0] line,         // Pointer content
  output logic                   saturated     // Pointer at maximum
);
  logic [LINE_W-1:0] line_r;
  logic [LINE_W-1:0] line_nxt;

  // Preset wins over a simultaneous step
  assign line_nxt  = preset ? start_line : (step ? rslp_sat_inc(line_r) : line_r);
  assign line      = line_r;
  assign saturated = (line_r == LINE_MAX);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) line_r <= LINE_RST;
    else        line_r <= line_nxt;
  end

  property p_sat_hold;
    @(posedge clk) disable iff (!rst_n)
      (line_r == LINE_MAX) && !preset |=> (line_r == LINE_MAX);
  endproperty
  a_sat_hold: assert property (p_sat_hold) else $error("pointer wrapped past maximum");

  property p_step;
    @(posedge clk) disable iff (!rst_n)
      step && !preset && (line_r != LINE_MAX) |=> (line_r == $past(line_r) + LINE_STEP);
  endproperty
  a_step: assert property (p_step) else $error("pointer did not advance by one");

  property p_preset;
    @(posedge clk) disable iff (!rst_n)
      preset |=> (line_r == $past(start_line));
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not copy start line");

  property p_idle;
    @(posedge clk) disable iff (!rst_n)
      !step && !preset |=> $stable(line_r);
  endproperty
  a_idle: assert property (p_idle) else $error("pointer moved without a cause");
endmodule : rslp_pointer
